/* File: cycle_sequencer.sv */
// per machine cycle sequencer of an 8-bit core: bus sources and activity
// assumes the decoder supplies class and rom-space flag at opcode fetch
`timescale 1ns/100ps
`default_nettype none
`include "seq_cfg.svh"

// What this block does
// - direct data ops take four cycles
// - direct rom operand: cycle four reads rom
// - immediate accumulator ops take four cycles
// - literal register load takes four cycles
// - literal load to rom space reads rom
// - short direct ops hold plus one
// - subroutine call takes four cycles
// - interrupt entry takes one cycle
// - absolute jump takes four cycles
// - bit test branches take five cycles
// - bit branch rom operand: cycles three, five
// - subroutine exit pops return in two
// - interrupt exit pops, swaps flags, two
// - rotate through carry holds plus one
// - stop and wait take two cycles
// - early values valid at cycle start only
// - short lived values end at t18
// - wake from stop adds startup, sixteen
module cycle_sequencer import seq_pkg::*; #(
   parameter int PHASES     = `MC_PHASES,
   parameter int START_CLKS = `OSC_START_CLKS,
   parameter int EXTRA_CLKS = `STOP_EXTRA_OSC
) (
   // clock and reset
   input  wire logic      core_clk,
   input  wire logic      reset,
   // opcode fetch request from the decoder
   input  wire logic      fetch_valid,
   input  wire op_class_t fetch_class,
   input  wire logic      fetch_rom_space,
   output logic           fetch_ready,
   // interrupt request, a level
   input  wire logic      irq_req,
   // per cycle bus and activity
   output addr_sel_t      addr_sel,
   output data_sel_t      data_sel,
   output act_t           activity,
   output logic [2:0]     cycle_num,
   output logic           bus_early_ok,
   output logic           bus_short_ok,
   output logic           push_ret,
   output logic           flag_set_swap,
   output logic           instr_done,
   // oscillator control
   output logic           osc_halt,
   output logic           osc_idle
);
   // ==========================================================
   // registers
   state_t       state_ff;        // sequencer state
   state_t       nxt_state;
   op_class_t    class_ff;        // class held for the instruction
   op_class_t    nxt_class;
   logic         rom_ff;          // operand lies in rom data space
   logic         nxt_rom;
   logic [2:0]   cyc_ff;          // machine cycle, 1-based
   logic [2:0]   nxt_cyc;
   logic [7:0]   phase_ff;        // phase within machine cycle
   logic [7:0]   nxt_phase;
   logic [15:0]  wake_ff;         // wake-up countdown after stop
   logic [15:0]  nxt_wake;
   logic         halt_ff;         // oscillator stopped
   logic         nxt_halt;
   logic         idle_ff;         // oscillator waiting
   logic         nxt_idle;
   step_t        step_ff;         // current table row
   step_t        nxt_step;
   logic         early_ok_ff;
   logic         short_ok_ff;
   logic         ready_ff;
   logic         push_ff;
   logic         swap_ff;
   logic         done_ff;
   logic         nxt_push;
   logic         nxt_swap;
   logic         nxt_done;

   // ==========================================================
   // decode of timing
   localparam logic [7:0]  LAST_PHASE = 8'(PHASES - 1);
   localparam logic [15:0] WAKE_CLKS  = 16'(START_CLKS + EXTRA_CLKS);

   wire        cyc_end   = (phase_ff == LAST_PHASE);   // machine cycle ends
   wire [2:0]  last_cyc  = cycle_count(class_ff);
   wire        instr_end = (state_ff == ST_RUN) && cyc_end
                           && (cyc_ff == last_cyc);
   // a new instruction may start when free or at the last phase
   wire        free_slot = (state_ff == ST_FREE) || instr_end;
   wire        take_irq  = free_slot && irq_req && !halt_ff;
   wire        take_op   = free_slot && fetch_valid && !irq_req
                           && !halt_ff && !idle_ff;
   wire        wake_go   = free_slot && irq_req && halt_ff;

   // ==========================================================
   // machine cycles per class
   function automatic logic [2:0] cycle_count(input op_class_t c);
      case (c)
         CL_INT:                      cycle_count = `CYC_ONE;
         CL_BRANCH_BIT:               cycle_count = `CYC_FIVE;
         CL_BRANCH_FLAG, CL_SUB_EXIT,
         CL_INT_EXIT:                 cycle_count = `CYC_TWO;
         CL_STOP, CL_WAIT:            cycle_count = `CYC_TWO;
         default:                     cycle_count = `CYC_FOUR;
      endcase
   endfunction : cycle_count

   // ==========================================================
   // one row of the cycle table
   function automatic step_t row(input addr_sel_t a, input data_sel_t d,
                                 input act_t x, input logic e,
                                 input logic s);
      row = '{addr: a, data: d, act: x, early: e, short_lived: s};
   endfunction : row

   // table lookup by class, rom flag and cycle
   function automatic step_t lookup(input op_class_t c, input logic r,
                                    input logic [2:0] n);
      lookup = row(AD_OPCODE, DT_OPCODE, AC_DECODE, 1'b1, 1'b0);
      if (c == CL_INT) begin
         // vector, push and flag swap in one cycle
         lookup = row(AD_NEXT_OPCODE, DT_NEXT_INSTR, AC_CALC_INT,
                      1'b1, 1'b0);
      end else if (n != 3'h1) begin
         case (c)
            CL_DIRECT: begin
               case (n)
                  3'h2: lookup = row(AD_PLUS1, DT_OPERAND_ADDR,
                                     AC_ADDR_DS, 1'b0, 1'b0);
                  3'h3: lookup = row(AD_PLUS1, DT_OPERAND_ADDR,
                                     AC_READ_OP, 1'b1, r);
                  default: lookup = r ?
                     row(AD_ROM_DS, DT_ROM_DATA, AC_EXECUTE,
                         1'b1, 1'b1) :
                     row(AD_PLUS2, DT_NEXT_INSTR, AC_EXECUTE,
                         1'b0, 1'b0);
               endcase
            end
            CL_IMM: begin
               case (n)
                  3'h2: lookup = row(AD_PLUS1, DT_IMMEDIATE, AC_IDLE,
                                     1'b0, 1'b0);
                  3'h3: lookup = row(AD_PLUS1, DT_IMMEDIATE,
                                     AC_READ_OP, 1'b1, 1'b0);
                  default: lookup = row(AD_PLUS2, DT_NEXT_INSTR,
                                     AC_EXECUTE, 1'b1, 1'b0);
               endcase
            end
            CL_MOVE_LIT_REG: begin
               case (n)
                  3'h2: lookup = row(AD_PLUS1, DT_REG_ADDR,
                                     AC_READ_REG_ADDR, r, 1'b0);
                  3'h3: lookup = row(AD_PLUS2, DT_IMMEDIATE,
                                     AC_READ_IMM, 1'b0, r);
                  default: lookup = r ?
                     row(AD_ROM_DS, DT_ROM_DATA, AC_WRITE_REG,
                         1'b0, 1'b1) :
                     row(AD_PLUS3, DT_NEXT_INSTR, AC_WRITE_REG,
                         1'b0, 1'b0);
               endcase
            end
            CL_SHORT: begin
               case (n)
                  3'h2: lookup = row(AD_PLUS1, DT_NEXT_INSTR,
                                     AC_DEFINE_DS, 1'b0, 1'b0);
                  3'h3: lookup = row(AD_PLUS1, DT_NEXT_INSTR,
                                     AC_READ_OP, 1'b0, 1'b0);
                  default: lookup = row(AD_PLUS1, DT_NEXT_INSTR,
                                     AC_EXECUTE, 1'b0, 1'b0);
               endcase
            end
            CL_CALL: begin
               case (n)
                  3'h2: lookup = row(AD_PLUS1, DT_SUB_ADDR, AC_INC_SP,
                                     1'b0, 1'b0);
                  3'h3: lookup = row(AD_PLUS1, DT_SUB_ADDR,
                                     AC_PUSH_RET, 1'b0, 1'b0);
                  default: lookup = row(AD_PLUS2, DT_NEXT_INSTR,
                                     AC_CALC_SUB, 1'b1, 1'b0);
               endcase
            end
            CL_JUMP: begin
               case (n)
                  3'h2: lookup = row(AD_PLUS1, DT_JUMP_ADDR, AC_IDLE,
                                     1'b0, 1'b0);
                  3'h3: lookup = row(AD_PLUS1, DT_NEXT_INSTR,
                                     AC_READ_JUMP, 1'b0, 1'b0);
                  default: lookup = row(AD_PLUS2, DT_NEXT_INSTR,
                                     AC_CALC_JUMP, 1'b1, 1'b0);
               endcase
            end
            CL_BRANCH_FLAG:
               lookup = row(AD_PLUS1, DT_NEXT_INSTR, AC_CALC_OFFSET,
                            1'b0, 1'b0);
            CL_BRANCH_BIT: begin
               case (n)
                  3'h2: lookup = row(AD_PLUS1, DT_OPERAND_ADDR,
                                     AC_READ_OP, 1'b1, 1'b0);
                  3'h3: lookup = r ?
                     row(AD_ROM_DS, DT_ROM_DATA, AC_TEST_OP,
                         1'b0, 1'b1) :
                     row(AD_PLUS2, DT_BRANCH_VAL, AC_TEST_OP,
                         1'b1, 1'b0);
                  3'h4: lookup = row(AD_PLUS2, DT_BRANCH_VAL,
                                     AC_FETCH_BRANCH, 1'b1, 1'b0);
                  default: lookup = r ?
                     row(AD_ROM_DS, DT_ROM_DATA, AC_CALC_NEW,
                         1'b0, 1'b1) :
                     row(AD_PLUS3, DT_NEXT_INSTR, AC_CALC_NEW,
                         1'b1, 1'b0);
               endcase
            end
            CL_SUB_EXIT, CL_INT_EXIT:
               lookup = row(AD_RETURN, DT_NEXT_INSTR, AC_POP_RET,
                            1'b0, 1'b0);
            CL_ROTATE: begin
               case (n)
                  3'h2: lookup = row(AD_PLUS1, DT_NEXT_INSTR,
                                     AC_CALC_ACC, 1'b0, 1'b0);
                  3'h3: lookup = row(AD_PLUS1, DT_NEXT_INSTR,
                                AC_READ_ACC_SHIFT, 1'b0, 1'b0);
                  default: lookup = row(AD_PLUS1, DT_NEXT_INSTR,
                                     AC_NONE, 1'b0, 1'b0);
               endcase
            end
            CL_STOP:
               lookup = row(AD_PLUS1, DT_NEXT_INSTR, AC_OSC_HALT,
                            1'b0, 1'b0);
            CL_WAIT:
               lookup = row(AD_PLUS1, DT_NEXT_INSTR, AC_OSC_IDLE,
                            1'b0, 1'b0);
            default:
               lookup = row(AD_OPCODE, DT_OPCODE, AC_NONE, 1'b0, 1'b0);
         endcase
      end
   endfunction : lookup

   // ==========================================================
   // next state, class, cycle and phase
   always_comb begin
      nxt_state = state_ff;
      nxt_class = class_ff;
      nxt_rom   = rom_ff;
      nxt_cyc   = cyc_ff;
      nxt_phase = cyc_end ? 8'h00 : phase_ff + 8'h01;
      nxt_wake  = wake_ff;
      nxt_halt  = halt_ff;
      nxt_idle  = idle_ff;
      case (state_ff)
         ST_FREE, ST_RUN: begin
            if (take_irq) begin
               // interrupt wins over a pending opcode fetch
               nxt_state = ST_RUN;
               nxt_class = CL_INT;
               nxt_rom   = 1'b0;
               nxt_cyc   = 3'h1;
               nxt_phase = 8'h00;
               nxt_idle  = 1'b0;
            end else if (wake_go) begin
               // oscillator restarts before the entry cycle
               nxt_state = ST_WAKE;
               nxt_wake  = WAKE_CLKS;
               nxt_halt  = 1'b0;
            end else if (take_op) begin
               nxt_state = ST_RUN;
               nxt_class = fetch_class;
               nxt_rom   = fetch_rom_space;
               nxt_cyc   = 3'h1;
               nxt_phase = 8'h00;
            end else if (instr_end) begin
               nxt_state = ST_FREE;
               nxt_halt  = (class_ff == CL_STOP);
               nxt_idle  = (class_ff == CL_WAIT);
            end else if (state_ff == ST_RUN && cyc_end) begin
               nxt_cyc = cyc_ff + 3'h1;
            end
         end
         ST_WAKE: begin
            nxt_phase = 8'h00;
            if (wake_ff == 16'h0001) begin
               // extension over, run the normal entry cycle
               nxt_state = ST_RUN;
               nxt_class = CL_INT;
               nxt_rom   = 1'b0;
               nxt_cyc   = 3'h1;
            end else begin
               nxt_wake = wake_ff - 16'h0001;
            end
         end
         default: nxt_state = ST_FREE;
      endcase
   end

   // ==========================================================
   // outputs for the next clock, all registered
   wire        run_next   = (nxt_state == ST_RUN);
   wire        cyc_start  = run_next && (nxt_phase == 8'h00);
   wire        int_cycle  = cyc_start && (nxt_class == CL_INT);

   assign nxt_step = lookup(nxt_class, nxt_rom, nxt_cyc);
   assign nxt_push = int_cycle || (cyc_start && nxt_class == CL_CALL
                                   && nxt_cyc == 3'h3);
   // flag set swaps on entry and again on exit
   assign nxt_swap = int_cycle
                     || (cyc_start && nxt_class == CL_INT_EXIT
                         && nxt_cyc == 3'h2);
   assign nxt_done = instr_end;

   // ==========================================================
   // state registers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_ff <= ST_FREE;
         class_ff <= CL_DIRECT;
         rom_ff   <= 1'b0;
         cyc_ff   <= 3'h1;
         phase_ff <= 8'h00;
         wake_ff  <= 16'h0000;
         halt_ff  <= 1'b0;
         idle_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         class_ff <= nxt_class;
         rom_ff   <= nxt_rom;
         cyc_ff   <= nxt_cyc;
         phase_ff <= nxt_phase;
         wake_ff  <= nxt_wake;
         halt_ff  <= nxt_halt;
         idle_ff  <= nxt_idle;
      end
   end

   // ==========================================================
   // output registers; bus marks only while an instruction runs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         step_ff     <= '{addr: AD_OPCODE, data: DT_OPCODE,
                          act: AC_NONE, early: 1'b0, short_lived: 1'b0};
         early_ok_ff <= 1'b0;
         short_ok_ff <= 1'b0;
         ready_ff    <= 1'b0;
         push_ff     <= 1'b0;
         swap_ff     <= 1'b0;
         done_ff     <= 1'b0;
      end else begin
         step_ff     <= run_next ? nxt_step : step_ff;
         // early values may be sampled in the first phase only
         early_ok_ff <= run_next && nxt_step.early
                        && (nxt_phase == 8'h00);
         // short lived values drop at phase t18
         short_ok_ff <= run_next && (!nxt_step.short_lived
                        || nxt_phase < 8'(`SHORT_PHASE));
         ready_ff    <= (nxt_state == ST_FREE) && !nxt_halt
                        && !nxt_idle;
         push_ff     <= nxt_push;
         swap_ff     <= nxt_swap;
         done_ff     <= nxt_done;
      end
   end

   // ==========================================================
   // port drive
   assign fetch_ready   = ready_ff;
   assign addr_sel      = step_ff.addr;
   assign data_sel      = step_ff.data;
   assign activity      = step_ff.act;
   assign cycle_num     = cyc_ff;
   assign bus_early_ok  = early_ok_ff;
   assign bus_short_ok  = short_ok_ff;
   assign push_ret      = push_ff;
   assign flag_set_swap = swap_ff;
   assign instr_done    = done_ff;
   assign osc_halt      = halt_ff;
   assign osc_idle      = idle_ff;
endmodule : cycle_sequencer
`default_nettype wire

/* File: seq_cfg.svh */
// constants of the instruction cycle sequencer: counts, phases, timing
// assumes a 100 MHz core clock; included by the design
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH
// ==========================================================
// clock and oscillator timing
`define CLK_PERIOD_NS   10
`define OSC_START_NS    10000
`define OSC_START_CLKS  ((`OSC_START_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define STOP_EXTRA_OSC  16
// ==========================================================
// machine cycle phases
`define MC_PHASES       24
`define SHORT_PHASE     18
// ==========================================================
// machine cycles per instruction class
`define CYC_FOUR        3'h4
`define CYC_FIVE        3'h5
`define CYC_TWO         3'h2
`define CYC_ONE         3'h1
`endif

/* File: seq_pkg.sv */
// types of the instruction cycle sequencer
// assumes seq_cfg.svh holds the numeric constants
package seq_pkg;
   // ==========================================================
   // instruction class and addressing mode, given at opcode fetch
   typedef enum logic [3:0] {
      CL_DIRECT, CL_IMM, CL_MOVE_LIT_REG, CL_SHORT, CL_CALL, CL_INT,
      CL_JUMP, CL_BRANCH_FLAG, CL_BRANCH_BIT, CL_SUB_EXIT, CL_INT_EXIT,
      CL_ROTATE, CL_STOP, CL_WAIT
   } op_class_t;
   // ==========================================================
   // what sits on the program address bus
   typedef enum logic [2:0] {
      AD_OPCODE, AD_PLUS1, AD_PLUS2, AD_PLUS3, AD_ROM_DS, AD_RETURN,
      AD_NEXT_OPCODE
   } addr_sel_t;
   // what the data bus returns
   typedef enum logic [3:0] {
      DT_OPCODE, DT_OPERAND_ADDR, DT_IMMEDIATE, DT_NEXT_INSTR,
      DT_ROM_DATA, DT_REG_ADDR, DT_SUB_ADDR, DT_JUMP_ADDR, DT_BRANCH_VAL
   } data_sel_t;
   // what the core does this machine cycle
   typedef enum logic [4:0] {
      AC_NONE, AC_DECODE, AC_ADDR_DS, AC_READ_OP, AC_EXECUTE, AC_IDLE,
      AC_READ_REG_ADDR, AC_READ_IMM, AC_WRITE_REG, AC_INC_SP, AC_PUSH_RET,
      AC_CALC_SUB, AC_CALC_INT, AC_READ_JUMP, AC_CALC_JUMP, AC_CALC_OFFSET,
      AC_TEST_OP, AC_FETCH_BRANCH, AC_CALC_NEW, AC_POP_RET, AC_DEFINE_DS,
      AC_CALC_ACC, AC_READ_ACC_SHIFT, AC_OSC_HALT, AC_OSC_IDLE
   } act_t;
   // ==========================================================
   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_FREE = 3'b001,
      ST_RUN  = 3'b010,
      ST_WAKE = 3'b100
   } state_t;
   // one row of the cycle table
   typedef struct packed {
      addr_sel_t addr;
      data_sel_t data;
      act_t      act;
      logic      early;
      logic      short_lived;
   } step_t;
endpackage : seq_pkg

/* File: seq_asserts.sv */
// port checker of the cycle sequencer
// assumes seq_pkg is compiled first; bound onto every cycle_sequencer
`timescale 1ns/100ps
`default_nettype none
module seq_asserts import seq_pkg::*; #(
   parameter int PHASES     = 24,
   parameter int START_CLKS = 1000,
   parameter int EXTRA_CLKS = 16
) (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       reset,
   // fetch side
   input wire logic       fetch_valid,
   input wire op_class_t  fetch_class,
   input wire logic       fetch_rom_space,
   input wire logic       fetch_ready,
   input wire logic       irq_req,
   // per cycle outputs
   input wire addr_sel_t  addr_sel,
   input wire data_sel_t  data_sel,
   input wire act_t       activity,
   input wire logic [2:0] cycle_num,
   input wire logic       bus_early_ok,
   input wire logic       bus_short_ok,
   input wire logic       push_ret,
   input wire logic       flag_set_swap,
   input wire logic       instr_done,
   input wire logic       osc_halt,
   input wire logic       osc_idle
);
   // ==========================================================
   // one clock domain
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // rows 2..5 stand at least nine clocks
   a_row_stands: assert property (
      $changed(cycle_num) && cycle_num != 3'h1
      |=> $stable(cycle_num)[*8]) else $error("row too short");
   a_decode_row: assert property (
      activity == AC_DECODE |-> cycle_num == 3'h1
      && addr_sel == AD_OPCODE) else $error("decode row wrong");
   a_early_once: assert property (bus_early_ok |=> !bus_early_ok)
      else $error("early mark too long");
   a_short_tail: assert property (
      $fell(bus_short_ok) && data_sel == DT_ROM_DATA
      |-> (!bus_short_ok && data_sel == DT_ROM_DATA)[*6])
      else $error("short window open");
   a_rom_source: assert property (
      data_sel == DT_ROM_DATA |-> addr_sel == AD_ROM_DS)
      else $error("rom data, no rom address");
   a_call_push: assert property (push_ret && activity != AC_CALC_INT
      |-> activity == AC_PUSH_RET && cycle_num == 3'h3)
      else $error("stray push");
   a_int_entry: assert property (
      $changed(activity) && activity == AC_CALC_INT
      |-> push_ret && flag_set_swap && addr_sel == AD_NEXT_OPCODE)
      else $error("entry row wrong");
   a_swap_cause: assert property (
      flag_set_swap |-> activity == AC_CALC_INT
      || (activity == AC_POP_RET && cycle_num == 3'h2))
      else $error("stray flag swap");
   a_exit_return: assert property (activity == AC_POP_RET
      |-> addr_sel == AD_RETURN && cycle_num == 3'h2)
      else $error("pop row wrong");
   a_branch_last: assert property (activity == AC_CALC_NEW
      |-> cycle_num == 3'h5) else $error("branch end wrong");
   a_osc_stop: assert property (activity == AC_OSC_HALT
      |-> addr_sel == AD_PLUS1 && cycle_num == 3'h2)
      else $error("halt row wrong");
   // entry waits for the oscillator
   a_wake_delay: assert property ($fell(osc_halt)
      |-> (!push_ret && !osc_halt)[*8]) else $error("no wake time");
   // main scenarios
   c_entry: cover property (push_ret && activity == AC_CALC_INT);
   c_rom: cover property (data_sel == DT_ROM_DATA);
   c_wake: cover property ($fell(osc_halt));
endmodule : seq_asserts
bind cycle_sequencer seq_asserts #(.PHASES(PHASES), .START_CLKS(START_CLKS),
   .EXTRA_CLKS(EXTRA_CLKS)) u_seq_asserts (.core_clk, .reset, .fetch_valid,
   .fetch_class, .fetch_rom_space, .fetch_ready, .irq_req, .addr_sel,
   .data_sel, .activity, .cycle_num, .bus_early_ok, .bus_short_ok,
   .push_ret, .flag_set_swap, .instr_done, .osc_halt, .osc_idle);
`default_nettype wire

/* File: seq_rom_model.sv */
// program rom and data space behind the bus selects
// assumes the bench wires it to the sequencer outputs
`timescale 1ns/100ps
`default_nettype none
module seq_rom_model import seq_pkg::*; (
   // clock
   input wire logic      core_clk,
   // bus from the sequencer
   input wire addr_sel_t addr_sel,
   input wire logic      bus_short_ok,
   // byte on the data bus
   output logic [7:0]    rom_byte
);
   // ==========================================================
   // byte names its source; past t18 it flips, so late samples show
   initial rom_byte = 8'h00;
   always @(posedge core_clk) begin
      if (bus_short_ok) begin
         rom_byte <= {5'h00, addr_sel} ^ 8'ha5;
      end else begin
         rom_byte <= ~rom_byte;
      end
   end
endmodule : seq_rom_model
`default_nettype wire

/* File: cpu_instruction_cycle_sequencer_test.sv */
// self-checking bench of the cycle sequencer
// assumes design, checker and rom model compiled first
`timescale 1ns/100ps
`default_nettype none
module cpu_instruction_cycle_sequencer_test import seq_pkg::*;;
   localparam int PH = 24;       // phases per machine cycle
   localparam int SC = 4;        // short start-up
   localparam int EC = 16;       // extra clocks after stop
   logic       core_clk, reset, fetch_valid, fetch_rom_space, irq_req;
   logic       fetch_ready, bus_early_ok, bus_short_ok, push_ret;
   logic       flag_set_swap, instr_done, osc_halt, osc_idle;
   op_class_t  fetch_class;
   addr_sel_t  addr_sel;
   data_sel_t  data_sel;
   act_t       activity;
   logic [2:0] cycle_num;
   logic [7:0] rom_byte;
   int         fails, n_tests, cycles;
   cycle_sequencer #(.START_CLKS(SC), .EXTRA_CLKS(EC)) dut (.core_clk,
      .reset, .fetch_valid, .fetch_class, .fetch_rom_space, .fetch_ready,
      .irq_req, .addr_sel, .data_sel, .activity, .cycle_num, .bus_early_ok,
      .bus_short_ok, .push_ret, .flag_set_swap, .instr_done, .osc_halt,
      .osc_idle);
   seq_rom_model u_rom (.core_clk, .addr_sel, .bus_short_ok, .rom_byte);
   // ==========================================================
   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   // ==========================================================
   // one instruction: time it, keep last row's source
   task automatic instr(input op_class_t c, input logic rom,
                        input logic [2:0] n, input addr_sel_t last);
      int k;
      addr_sel_t a;
      @(posedge core_clk);
      fetch_class <= c;
      fetch_rom_space <= rom;
      fetch_valid <= 1'b1;
      do @(posedge core_clk); while (fetch_ready !== 1'b1);
      fetch_valid <= 1'b0;
      k = 0;
      do begin
         a = addr_sel;
         @(posedge core_clk);
         #1;
         k++;
      end while (instr_done !== 1'b1 && k < 200);
      check(k, n * PH);
      check(a, last);
   endtask : instr
   // irq entry; f offers a rival fetch
   task automatic enter_irq(input logic f, output int k);
      int j;
      @(posedge core_clk);
      irq_req <= 1'b1;
      fetch_valid <= f;
      k = 0;
      do begin @(posedge core_clk); #1; k++; end
      while (push_ret !== 1'b1 && k < 2000);
      check(flag_set_swap, 1'b1);
      check(activity, AC_CALC_INT);
      check(addr_sel, AD_NEXT_OPCODE);
      j = 0;
      do begin
         @(posedge core_clk);
         irq_req <= 1'b0;
         fetch_valid <= 1'b0;
         #1;
         j++;
      end while (instr_done !== 1'b1 && j < 100);
      check(j, PH);
   endtask : enter_irq
   // ==========================================================
   // scenarios
   task automatic t_reset;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      check(activity, AC_NONE);
      check(cycle_num, 3'h1);
      @(posedge core_clk);
      #1;
      check(fetch_ready, 1'b1);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_classes;
      instr(CL_DIRECT, 1'b0, 3'h4, AD_PLUS2);
      instr(CL_DIRECT, 1'b1, 3'h4, AD_ROM_DS);
      instr(CL_IMM, 1'b0, 3'h4, AD_PLUS2);
      instr(CL_MOVE_LIT_REG, 1'b0, 3'h4, AD_PLUS3);
      instr(CL_MOVE_LIT_REG, 1'b1, 3'h4, AD_ROM_DS);
      instr(CL_SHORT, 1'b0, 3'h4, AD_PLUS1);
      instr(CL_CALL, 1'b0, 3'h4, AD_PLUS2);
      instr(CL_JUMP, 1'b0, 3'h4, AD_PLUS2);
      instr(CL_BRANCH_FLAG, 1'b0, 3'h2, AD_PLUS1);
      instr(CL_BRANCH_BIT, 1'b0, 3'h5, AD_PLUS3);
      instr(CL_BRANCH_BIT, 1'b1, 3'h5, AD_ROM_DS);
      instr(CL_SUB_EXIT, 1'b0, 3'h2, AD_RETURN);
      instr(CL_INT_EXIT, 1'b0, 3'h2, AD_RETURN);
      instr(CL_ROTATE, 1'b0, 3'h4, AD_PLUS1);
      $display("t_classes done");
   endtask : t_classes
   // fetch held: next instruction follows with no gap
   task automatic t_back2back;
      int k;
      @(posedge core_clk);
      fetch_class <= CL_SHORT;
      fetch_valid <= 1'b1;
      do @(posedge core_clk); while (fetch_ready !== 1'b1);
      k = 0;
      repeat (2) begin
         do begin
            @(posedge core_clk);
            fetch_valid <= (k < 5 * PH);
            #1;
            k++;
         end while (instr_done !== 1'b1 && k < 400);
      end
      check(k, 8 * PH);
      $display("t_back2back done");
   endtask : t_back2back
   task automatic t_irq_stop_wait;
      int k;
      fetch_class <= CL_JUMP;
      enter_irq(1'b1, k);
      check(k, 1);
      instr(CL_STOP, 1'b0, 3'h2, AD_PLUS1);
      @(posedge core_clk);
      #1;
      check(osc_halt, 1'b1);
      enter_irq(1'b0, k);
      check(k >= SC + EC && k <= SC + EC + 3, 1'b1);
      instr(CL_WAIT, 1'b0, 3'h2, AD_PLUS1);
      @(posedge core_clk);
      #1;
      check(osc_idle, 1'b1);
      enter_irq(1'b0, k);
      check(k <= 3, 1'b1);
      $display("t_irq_stop_wait done");
   endtask : t_irq_stop_wait
   // ==========================================================
   // hang guard
   initial begin
      cycles = 0;
      forever begin
         @(posedge core_clk);
         cycles++;
         if (cycles == 20000) begin
            fails++;
            end_of_test;
         end
      end
   end
   initial begin
      reset = 1'b1;
      fetch_valid = 1'b0;
      fetch_class = CL_DIRECT;
      fetch_rom_space = 1'b0;
      irq_req = 1'b0;
      fails = 0;
      n_tests = 0;
      t_reset;
      t_classes;
      t_back2back;
      t_irq_stop_wait;
      end_of_test;
   end
endmodule : cpu_instruction_cycle_sequencer_test
`default_nettype wire
